// >>> logic/three_port_parallel_io.v
// three 8-bit parallel io ports (a, b, c) mapped as data-space registers
// assumes a single-cycle core data-space strobe; pad cells supply schmitt inputs
`timescale 1ns/1ns
`include "parallel_io_regs.vh"

// How it works
// - direction bit 0 makes the line input, 1 makes it output
// - input: data 0 enables pull-up, data 1 disables; output: data drives line
// - data register read returns pin levels for input lines
// - data register write stores value driven on output lines
// - bit n of each register controls and reports line n
// - direction registers read and write like ordinary locations; data registers do so on output lines only
// - reset clears port registers: all lines input, pull-up on lines that have one, port c excepted
// - port c data resets to 04h, line two high impedance
// - port c direction resets to 04h, line two output
// - drive fixed: a0-3 and b push-pull, rest open-drain
// - high-voltage open-drain lines have no pull-up
// - serial lines on port c drive AND of peripheral and data bit
// - port c lines carry serial clock, data, enable, power and infrared inputs
// - all lines sample through schmitt-trigger inputs
module three_port_parallel_io (
  input wire sys_clk_i,
  input wire rst_i,
  input wire [7:0] addr_i,
  input wire wr_en_i,
  input wire rd_en_i,
  input wire [7:0] wr_data_i,
  output reg [7:0] rd_data_o,
  input wire [7:0] port_a_pin_i,
  input wire [7:0] port_b_pin_i,
  input wire [7:0] port_c_pin_i,
  output wire [7:0] port_a_pin_o,
  output wire [7:0] port_b_pin_o,
  output wire [7:0] port_c_pin_o,
  output wire [7:0] port_a_pin_oe_o,
  output wire [7:0] port_b_pin_oe_o,
  output wire [7:0] port_c_pin_oe_o,
  output wire [7:0] port_a_pullup_o,
  output wire [7:0] port_b_pullup_o,
  output wire [7:0] port_c_pullup_o,
  input wire serial_clock_i,
  input wire serial_data_i,
  input wire serial_enable_line_i,
  output wire serial_clock_pin_o,
  output wire serial_data_pin_o,
  output wire power_interrupt_input_o,
  output wire infrared_interrupt_input_o
);

  // ********************************
  // register file
  // ********************************
  // one-hot select position of each mapped register
  localparam SEL_DATA_A = 0;
  localparam SEL_DATA_B = 1;
  localparam SEL_DATA_C = 2;
  localparam SEL_DIR_A = 3;
  localparam SEL_DIR_B = 4;
  localparam SEL_DIR_C = 5;
  // ports stacked a, b, c from the low end of the gathered views
  localparam PORT_A = 0;
  localparam PORT_B = 1;
  localparam PORT_C = 2;
  localparam PORT_COUNT = 3;
  localparam LINE_COUNT = 8;

  reg [7:0] port_a_data_latch_reg;
  reg [7:0] port_b_data_latch_reg;
  reg [7:0] port_c_data_latch_reg;
  reg [7:0] port_a_direction_reg;
  reg [7:0] port_b_direction_reg;
  reg [7:0] port_c_direction_reg;
  reg [7:0] rd_data_next;
  wire [5:0] reg_sel;
  wire [7:0] serial_out_c;
  wire [7:0] drive_c;

  // gathered views of the three ports, one byte per port
  wire [23:0] dir_all;
  wire [23:0] latch_all;
  wire [23:0] pin_all;
  wire [23:0] value_all;
  wire [23:0] pushpull_all;
  wire [23:0] has_pullup_all;
  wire [23:0] oe_all;
  wire [23:0] pullup_all;
  wire [23:0] view_all;

  // read mux: input lines show the pin, output lines show the latch
  function [7:0] line_view;
    input [7:0] dir;
    input [7:0] latch;
    input [7:0] pin;
    begin
      line_view = (dir & latch) | (~dir & pin);
    end
  endfunction

  // pull-up only where the line has one and both bits are zero
  function [7:0] pullup_on;
    input [7:0] dir;
    input [7:0] latch;
    input [7:0] has_pullup;
    begin
      pullup_on = ~dir & ~latch & has_pullup;
    end
  endfunction

  // drive value and enable: push-pull drives both levels, open-drain only sinks
  function [7:0] drive_en;
    input [7:0] dir;
    input [7:0] value;
    input [7:0] pushpull;
    begin
      drive_en = dir & (pushpull | ~value);
    end
  endfunction

  // address decode shared by the write and read paths so both always agree
  function [5:0] reg_select;
    input [7:0] addr;
    begin
      reg_select = 6'h00;
      case (addr)
        `PIO_ADDR_DATA_A: reg_select[SEL_DATA_A] = 1'b1;
        `PIO_ADDR_DATA_B: reg_select[SEL_DATA_B] = 1'b1;
        `PIO_ADDR_DATA_C: reg_select[SEL_DATA_C] = 1'b1;
        `PIO_ADDR_DIR_A: reg_select[SEL_DIR_A] = 1'b1;
        `PIO_ADDR_DIR_B: reg_select[SEL_DIR_B] = 1'b1;
        `PIO_ADDR_DIR_C: reg_select[SEL_DIR_C] = 1'b1;
        default: reg_select = 6'h00;
      endcase
    end
  endfunction

  assign reg_sel = reg_select(addr_i);

  // ********************************
  // register writes
  // ********************************
  // register writes; port c comes out of reset with line two driven high-z
  // clear on reset, port c data and direction to 04h
  always @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      port_a_data_latch_reg <= `PIO_RST_DATA_A;
      port_b_data_latch_reg <= `PIO_RST_DATA_B;
      port_c_data_latch_reg <= `PIO_RST_DATA_C;
      port_a_direction_reg <= `PIO_RST_DIR_A;
      port_b_direction_reg <= `PIO_RST_DIR_B;
      port_c_direction_reg <= `PIO_RST_DIR_C;
    end else if (wr_en_i) begin
      if (reg_sel[SEL_DATA_A]) begin
        port_a_data_latch_reg <= wr_data_i;
      end
      if (reg_sel[SEL_DATA_B]) begin
        port_b_data_latch_reg <= wr_data_i;
      end
      if (reg_sel[SEL_DATA_C]) begin
        port_c_data_latch_reg <= wr_data_i;
      end
      if (reg_sel[SEL_DIR_A]) begin
        port_a_direction_reg <= wr_data_i;
      end
      if (reg_sel[SEL_DIR_B]) begin
        port_b_direction_reg <= wr_data_i;
      end
      if (reg_sel[SEL_DIR_C]) begin
        port_c_direction_reg <= wr_data_i;
      end
    end
  end

  // ********************************
  // read path
  // ********************************
  // read decode; pins are taken as already synchronous (schmitt pads outside)
  // pins read back
  always @* begin
    rd_data_next = `PIO_READ_ZERO;
    if (reg_sel[SEL_DATA_A]) begin
      rd_data_next = view_all[PORT_A*LINE_COUNT +: LINE_COUNT];
    end
    if (reg_sel[SEL_DATA_B]) begin
      rd_data_next = view_all[PORT_B*LINE_COUNT +: LINE_COUNT];
    end
    if (reg_sel[SEL_DATA_C]) begin
      rd_data_next = view_all[PORT_C*LINE_COUNT +: LINE_COUNT];
    end
    if (reg_sel[SEL_DIR_A]) begin
      rd_data_next = port_a_direction_reg;
    end
    if (reg_sel[SEL_DIR_B]) begin
      rd_data_next = port_b_direction_reg;
    end
    if (reg_sel[SEL_DIR_C]) begin
      rd_data_next = port_c_direction_reg;
    end
  end

  // registered read data, one cycle after the read strobe
  // ordinary location reads
  always @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rd_data_o <= `PIO_READ_ZERO;
    end else if (rd_en_i) begin
      rd_data_o <= rd_data_next;
    end
  end

  // ********************************
  // gathered per-port views
  // ********************************
  // the same cell template serves all three ports once they sit side by side
  assign dir_all = {port_c_direction_reg, port_b_direction_reg, port_a_direction_reg};
  assign latch_all = {port_c_data_latch_reg, port_b_data_latch_reg, port_a_data_latch_reg};
  assign pin_all = {port_c_pin_i, port_b_pin_i, port_a_pin_i};
  // port c drives the serial-gated value; a and b drive the latch as written
  assign value_all = {drive_c, port_b_data_latch_reg, port_a_data_latch_reg};
  assign pushpull_all = {`PIO_PUSHPULL_C, `PIO_PUSHPULL_B, `PIO_PUSHPULL_A};
  assign has_pullup_all = {`PIO_PULLUP_C, `PIO_PULLUP_B, `PIO_PULLUP_A};

  // ********************************
  // per-port cells
  // ********************************
  genvar port_n;
  generate
    for (port_n = 0; port_n < PORT_COUNT; port_n = port_n + 1) begin : port_cell
      localparam SLICE_LO = port_n * LINE_COUNT;
      wire [7:0] cell_dir;
      wire [7:0] cell_latch;
      wire [7:0] cell_pin;
      wire [7:0] cell_value;
      wire [7:0] cell_pushpull;
      wire [7:0] cell_has_pullup;
      // one byte of each gathered view per port
      assign cell_dir = dir_all[SLICE_LO +: LINE_COUNT];
      assign cell_latch = latch_all[SLICE_LO +: LINE_COUNT];
      assign cell_pin = pin_all[SLICE_LO +: LINE_COUNT];
      assign cell_value = value_all[SLICE_LO +: LINE_COUNT];
      assign cell_pushpull = pushpull_all[SLICE_LO +: LINE_COUNT];
      assign cell_has_pullup = has_pullup_all[SLICE_LO +: LINE_COUNT];
      assign oe_all[SLICE_LO +: LINE_COUNT] = drive_en(cell_dir, cell_value, cell_pushpull);
      assign pullup_all[SLICE_LO +: LINE_COUNT] = pullup_on(cell_dir, cell_latch, cell_has_pullup);
      assign view_all[SLICE_LO +: LINE_COUNT] = line_view(cell_dir, cell_latch, cell_pin);
    end
  endgenerate

  // ********************************
  // port c shared lines
  // ********************************
  // open-drain lines: gating the latch low is all the peripheral can do to a pin
  genvar line_n;
  generate
    for (line_n = 0; line_n < LINE_COUNT; line_n = line_n + 1) begin : c_line_cell
      if (line_n == `PIO_BIT_SCLK) begin : clock_line
        assign serial_out_c[line_n] = serial_clock_i;
      end else if (line_n == `PIO_BIT_SDATA) begin : data_line
        assign serial_out_c[line_n] = serial_data_i;
      end else if (line_n == `PIO_BIT_SEN) begin : enable_line
        assign serial_out_c[line_n] = serial_enable_line_i;
      end else begin : plain_line
        // lines the peripheral never touches pass the latch unchanged
        assign serial_out_c[line_n] = 1'b1;
      end
      // wired and
      // input lines keep the plain latch so the pull-up choice stays software's
      assign drive_c[line_n] = port_c_data_latch_reg[line_n] &
        (serial_out_c[line_n] | ~port_c_direction_reg[line_n]);
    end
  endgenerate

  // ********************************
  // pin outputs
  // ********************************
  // port a: lines 0-3 push-pull, 4-7 open-drain without pull-up
  assign port_a_pin_o = value_all[PORT_A*LINE_COUNT +: LINE_COUNT];
  assign port_a_pin_oe_o = oe_all[PORT_A*LINE_COUNT +: LINE_COUNT];
  assign port_a_pullup_o = pullup_all[PORT_A*LINE_COUNT +: LINE_COUNT];

  // port b: all push-pull with pull-ups
  assign port_b_pin_o = value_all[PORT_B*LINE_COUNT +: LINE_COUNT];
  assign port_b_pin_oe_o = oe_all[PORT_B*LINE_COUNT +: LINE_COUNT];
  assign port_b_pullup_o = pullup_all[PORT_B*LINE_COUNT +: LINE_COUNT];

  // port c: all open-drain, serial-gated value on the shared lines
  assign port_c_pin_o = value_all[PORT_C*LINE_COUNT +: LINE_COUNT];
  assign port_c_pin_oe_o = oe_all[PORT_C*LINE_COUNT +: LINE_COUNT];
  assign port_c_pullup_o = pullup_all[PORT_C*LINE_COUNT +: LINE_COUNT];

  // pin levels handed to the serial peripheral and the interrupt latches
  // special line taps
  assign serial_clock_pin_o = port_c_pin_i[`PIO_BIT_SCLK];
  assign serial_data_pin_o = port_c_pin_i[`PIO_BIT_SDATA];
  assign power_interrupt_input_o = port_c_pin_i[`PIO_BIT_POWER_INTERRUPT_INPUT];
  assign infrared_interrupt_input_o = port_c_pin_i[`PIO_BIT_INFRARED_INTERRUPT_INPUT];

endmodule

// >>> logic/parallel_io_regs.vh
// register offsets, reset values and line masks of the three-port parallel io block
// assumes an 8-bit data-space address from the core
`ifndef PARALLEL_IO_REGS_VH
`define PARALLEL_IO_REGS_VH
// ********************************
// data-space offsets
// ********************************
`define PIO_ADDR_DATA_A 8'hc0
`define PIO_ADDR_DATA_B 8'hc1
`define PIO_ADDR_DATA_C 8'hc2
`define PIO_ADDR_DIR_A 8'hc4
`define PIO_ADDR_DIR_B 8'hc5
`define PIO_ADDR_DIR_C 8'hc6
// ********************************
// reset values
// ********************************
`define PIO_RST_DATA_A 8'h00
`define PIO_RST_DATA_B 8'h00
`define PIO_RST_DATA_C 8'h04
`define PIO_RST_DIR_A 8'h00
`define PIO_RST_DIR_B 8'h00
`define PIO_RST_DIR_C 8'h04
// ********************************
// per-line drive options (1 = push-pull, else open-drain)
// ********************************
`define PIO_PUSHPULL_A 8'h0f
`define PIO_PUSHPULL_B 8'hff
`define PIO_PUSHPULL_C 8'h00
// lines that own a pull-up (high-voltage open-drain lines have none)
`define PIO_PULLUP_A 8'h0f
`define PIO_PULLUP_B 8'hff
`define PIO_PULLUP_C 8'h0f
// lines shared with the serial peripheral: clock 0, data 1, enable 3
`define PIO_SERIAL_C 8'h0b
`define PIO_BIT_SCLK 0
`define PIO_BIT_SDATA 1
`define PIO_BIT_SEN 3
`define PIO_BIT_POWER_INTERRUPT_INPUT 4
`define PIO_BIT_INFRARED_INTERRUPT_INPUT 6
`define PIO_READ_ZERO 8'h00
`endif

// >>> tb/pio_board.sv
// board model: each pin line driven by the block, pulled up, or set by the bench
// assumes oe high means the block drives the line
`timescale 1ns/1ns
module pio_board (
  input wire [7:0] out_i,
  input wire [7:0] oe_i,
  input wire [7:0] pullup_i,
  input wire [7:0] ext_i,
  output wire [7:0] pin_o
);
  // resolved wire level
  // the bench source stays weaker than the pull-up, so a pulled line reads high
  assign pin_o = (oe_i & out_i) | (~oe_i & pullup_i) | (~oe_i & ~pullup_i & ext_i);
endmodule

// >>> tb/pio_asserts.sv
// checker for the parallel io block, sees only its ports
// assumes one clock and an active-high reset
`timescale 1ns/1ns
module pio_asserts (
  input wire sys_clk_i,
  input wire rst_i,
  input wire [7:0] addr_i,
  input wire wr_en_i,
  input wire rd_en_i,
  input wire [7:0] wr_data_i,
  input wire [7:0] rd_data_o,
  input wire [7:0] port_a_pin_i,
  input wire [7:0] port_c_pin_i,
  input wire [7:0] port_a_pin_oe_o,
  input wire [7:0] port_b_pin_o,
  input wire [7:0] port_b_pin_oe_o,
  input wire [7:0] port_c_pin_o,
  input wire [7:0] port_c_pin_oe_o,
  input wire [7:0] port_a_pullup_o,
  input wire [7:0] port_c_pullup_o,
  input wire serial_clock_pin_o,
  input wire power_interrupt_input_o,
  input wire infrared_interrupt_input_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  AST_DIR_B: assert property (wr_en_i && addr_i == 8'hc5 |=> port_b_pin_oe_o == $past(wr_data_i))
    else $error("direction write not seen on enables");
  AST_DATA_B: assert property (wr_en_i && addr_i == 8'hc1 |=> port_b_pin_o == $past(wr_data_i))
    else $error("data write not seen on pins");
  AST_RD_PIN: assert property (rd_en_i && addr_i == 8'hc0 && !port_a_pin_oe_o[0]
    |=> rd_data_o[0] == $past(port_a_pin_i[0])) else $error("input line read wrong");
  AST_UNMAPPED: assert property (rd_en_i && !(addr_i inside {8'hc0, 8'hc1, 8'hc2, 8'hc4,
    8'hc5, 8'hc6}) |=> rd_data_o == 8'h00) else $error("unmapped read not zero");
  AST_RD_HOLD: assert property (!rd_en_i |=> $stable(rd_data_o))
    else $error("read data moved without a read");
  AST_NO_PU_HV: assert property ((port_a_pullup_o[7:4] | port_c_pullup_o[7:4]) == 4'h0)
    else $error("pull-up on high-voltage line");
  AST_PU_OE: assert property ((port_a_pullup_o & port_a_pin_oe_o) == 8'h00)
    else $error("pull-up on a driven line");
  AST_OD_LOW: assert property ((port_c_pin_oe_o & port_c_pin_o) == 8'h00)
    else $error("open-drain line driven high");
  AST_SHARED: assert property (power_interrupt_input_o == port_c_pin_i[4]
    && infrared_interrupt_input_o == port_c_pin_i[6] && serial_clock_pin_o == port_c_pin_i[0])
    else $error("shared line level wrong");
endmodule

// >>> tb/three_port_parallel_io_bench.sv
// bench for the parallel io block: register accesses checked against pins
// assumes one access per two cycles, inputs moved on the falling edge
`timescale 1ns/1ns
`include "parallel_io_regs.vh"
module three_port_parallel_io_bench;
  reg sys_clk_i = 0, rst_i = 1, wr_en_i = 0, rd_en_i = 0, sclk = 1, sdat = 1, serial_enable_line = 1;
  reg [7:0] addr_i = 0, wr_data_i = 0, ext_a = 0, ext_b = 0, ext_c = 0;
  wire [7:0] rd_data_o, pa_i, pb_i, pc_i, pa_o, pb_o, pc_o, pa_oe, pb_oe, pc_oe, pa_pu, pb_pu, pc_pu;
  wire sck_p, sda_p, pwr, ir;
  integer n_errors = 0, compares = 0;
  three_port_parallel_io three_port_parallel_io_i (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
    .addr_i(addr_i), .wr_en_i(wr_en_i), .rd_en_i(rd_en_i), .wr_data_i(wr_data_i),
    .rd_data_o(rd_data_o), .port_a_pin_i(pa_i), .port_b_pin_i(pb_i), .port_c_pin_i(pc_i),
    .port_a_pin_o(pa_o), .port_b_pin_o(pb_o), .port_c_pin_o(pc_o), .port_a_pin_oe_o(pa_oe),
    .port_b_pin_oe_o(pb_oe), .port_c_pin_oe_o(pc_oe), .port_a_pullup_o(pa_pu),
    .port_b_pullup_o(pb_pu), .port_c_pullup_o(pc_pu), .serial_clock_i(sclk),
    .serial_data_i(sdat), .serial_enable_line_i(serial_enable_line), .serial_clock_pin_o(sck_p),
    .serial_data_pin_o(sda_p), .power_interrupt_input_o(pwr), .infrared_interrupt_input_o(ir));
  pio_board pio_board_a (.out_i(pa_o), .oe_i(pa_oe), .pullup_i(pa_pu), .ext_i(ext_a), .pin_o(pa_i));
  pio_board pio_board_b (.out_i(pb_o), .oe_i(pb_oe), .pullup_i(pb_pu), .ext_i(ext_b), .pin_o(pb_i));
  pio_board pio_board_c (.out_i(pc_o), .oe_i(pc_oe), .pullup_i(pc_pu), .ext_i(ext_c), .pin_o(pc_i));
  // ********************************
  // access tasks
  // ********************************
  task chk(input [7:0] seen, input [7:0] exp);
    begin
      compares = compares + 1;
      if (seen !== exp) begin
        n_errors = n_errors + 1;
        $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  // strobes last one cycle, so each access spans two falling edges
  task wr(input [7:0] a, input [7:0] d);
    begin
      @(negedge sys_clk_i) {addr_i, wr_data_i, wr_en_i} = {a, d, 1'b1};
      @(negedge sys_clk_i) wr_en_i = 0;
    end
  endtask
  task rd(input [7:0] a, input [7:0] exp);
    begin
      @(negedge sys_clk_i) {addr_i, rd_en_i} = {a, 1'b1};
      @(negedge sys_clk_i) rd_en_i = 0;
      chk(rd_data_o, exp);
    end
  endtask
  task end_of_test;
    begin
      if (n_errors == 0 && compares > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
    end
  endtask
  initial forever #2 sys_clk_i = ~sys_clk_i;
  // watchdog: a run that overstays counts as a mismatch
  initial begin
    #20000 n_errors = n_errors + 1;
    end_of_test;
  end
  initial begin
    repeat (3) @(negedge sys_clk_i);
    rst_i = 0;
    chk(pa_pu, 8'h0f); chk(pb_pu, 8'hff); chk(pc_pu, 8'h0b); chk(pc_oe, 8'h00);
    rd(`PIO_ADDR_DATA_A, 8'h0f); rd(`PIO_ADDR_DATA_B, 8'hff); rd(`PIO_ADDR_DATA_C, 8'h0f);
    rd(`PIO_ADDR_DIR_A, 8'h00); rd(`PIO_ADDR_DIR_B, 8'h00); rd(`PIO_ADDR_DIR_C, 8'h04);
    wr(`PIO_ADDR_DIR_B, 8'hff); wr(`PIO_ADDR_DATA_B, 8'ha5); // unbonded b lines as outputs
    chk(pb_o, 8'ha5); chk(pb_oe, 8'hff); rd(`PIO_ADDR_DATA_B, 8'ha5);
    chk(pb_pu, 8'h00);
    wr(`PIO_ADDR_DIR_A, 8'hf0); wr(`PIO_ADDR_DATA_A, 8'h5a); // whole-byte writes only
    chk(pa_o, 8'h5a);
    ext_a = 8'h02;
    chk(pa_pu, 8'h05); chk(pa_oe, 8'ha0); rd(`PIO_ADDR_DATA_A, 8'h57);
    wr(8'hc3, 8'hff); rd(8'hc3, 8'h00); rd(`PIO_ADDR_DIR_A, 8'hf0);
    // serial lines output with data one, latch lines left as inputs
    wr(`PIO_ADDR_DIR_C, 8'h0b); wr(`PIO_ADDR_DATA_C, 8'h0b);
    // bench source holds released open-drain line 1 high and inputs 4 and 6 high; lines 0 and 3 driven low
    @(negedge sys_clk_i) {sclk, serial_enable_line, ext_c} = {1'b0, 1'b0, 8'h5a};
    #1 chk(pc_oe, 8'h09); chk(pc_o, 8'h02); chk(pc_pu, 8'h04);
    chk({6'h00, sck_p, sda_p}, 8'h01); chk({6'h00, pwr, ir}, 8'h03);
    end_of_test;
  end
endmodule
bind three_port_parallel_io pio_asserts pio_asserts_i (.sys_clk_i, .rst_i, .addr_i, .wr_en_i,
  .rd_en_i, .wr_data_i, .rd_data_o, .port_a_pin_i, .port_c_pin_i, .port_a_pin_oe_o,
  .port_b_pin_o, .port_b_pin_oe_o, .port_c_pin_o, .port_c_pin_oe_o, .port_a_pullup_o,
  .port_c_pullup_o, .serial_clock_pin_o, .power_interrupt_input_o, .infrared_interrupt_input_o);
